// [cpsc_defs.svh]
// Constants for the carrier port settings command handler
`ifndef CPSC_DEFS_SVH
`define CPSC_DEFS_SVH

// ----------------------------------------------------------------------------
// Message codes
// ----------------------------------------------------------------------------
`define CPSC_FUNC_PORT 8'h45
`define CPSC_FUNC_EXC 8'hc5
`define CPSC_SUB_RD 8'h00
`define CPSC_SUB_WR 8'h01
`define CPSC_SUB_FW 8'h02
`define CPSC_SUB_HW 8'h03
`define CPSC_EXC_ILL_FUNC 8'h01
`define CPSC_EXC_ILL_VAL 8'h03

// ----------------------------------------------------------------------------
// Ports and settings record layout
// ----------------------------------------------------------------------------
`define CPSC_NPORT 2
`define CPSC_PORT_W 1
`define CPSC_REC_LAST 4'd12
`define CPSC_OFF_PORT 4'd0
`define CPSC_OFF_BAUD 4'd1
`define CPSC_OFF_SIZE 4'd5
`define CPSC_OFF_PARITY 4'd6
`define CPSC_OFF_STOP 4'd7
`define CPSC_OFF_FLOW 4'd8
`define CPSC_OFF_ADDR 4'd9
`define CPSC_OFF_ECHO 4'd10
`define CPSC_OFF_RES 4'd11

// ----------------------------------------------------------------------------
// Field encodings and limits
// ----------------------------------------------------------------------------
`define CPSC_BAUD_9600 32'd9600
`define CPSC_BAUD_19200 32'd19200
`define CPSC_BAUD_38400 32'd38400
`define CPSC_BAUD_57600 32'd57600
`define CPSC_BAUD_115200 32'd115200
`define CPSC_SIZE_8 8'h08
`define CPSC_PAR_NONE 8'h00
`define CPSC_PAR_EVEN 8'h02
`define CPSC_STOP_1 8'h01
`define CPSC_STOP_2 8'h02
`define CPSC_FLOW_NONE 8'h00
`define CPSC_ADDR_MIN 8'd1
`define CPSC_ADDR_MAX 8'd247
`define CPSC_ECHO_MIN 8'd1
`define CPSC_ECHO_MAX 8'd40
`define CPSC_RES_M 16'd1
`define CPSC_RES_DM 16'd10
`define CPSC_RES_CM 16'd100
`define CPSC_RES_MM 16'd1000

// ----------------------------------------------------------------------------
// Reset values of each port's settings
// ----------------------------------------------------------------------------
`define CPSC_RST_BAUD 32'd115200
`define CPSC_RST_PARITY 8'h00
`define CPSC_RST_STOP 8'h01
`define CPSC_RST_ADDR 8'd1
`define CPSC_RST_ECHO 8'd40
`define CPSC_RST_RES 16'd1000

// ----------------------------------------------------------------------------
// Answer byte indices (byte 0 is the function code)
// ----------------------------------------------------------------------------
`define CPSC_A_RD_NPORT 8'd2
`define CPSC_A_RD_CUR 8'd3
`define CPSC_A_RD_REC 8'd4
`define CPSC_A_RD_LAST (8'd3 + 8'd13 * 8'(`CPSC_NPORT))
`define CPSC_A_PART 8'd2
`define CPSC_A_FW_VER 8'd34
`define CPSC_A_FW_LAST 8'd41
`define CPSC_A_HW_SER 8'd34
`define CPSC_A_HW_OPT 8'd66
`define CPSC_A_HW_LAST 8'd69

// ----------------------------------------------------------------------------
// Answer buffer
// ----------------------------------------------------------------------------
`define CPSC_FIFO_W 9
`define CPSC_FIFO_D 16

`endif

// [cpsc_pkg.sv]
// Types shared by the carrier port settings command handler
package cpsc_pkg;

  typedef enum logic [2:0] {
    st_func,
    st_sub,
    st_rec,
    st_skip,
    st_ans
  } cpsc_state_t;

endpackage

// [cpsc_fifo.sv]
// Answer byte FIFO with registered output stage
`timescale 1ns/1ps
module cpsc_fifo
  import cpsc_pkg::*;
#(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
)(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] cnt_q;
  logic push;
  logic load;

  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign push = in_valid && in_ready;
  assign load = (cnt_q != '0) && (!out_valid || out_ready);

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wr_ptr_q] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_q <= AW'(wr_ptr_q + 1'b1);
      end
      if (load)
      begin
        rd_ptr_q <= AW'(rd_ptr_q + 1'b1);
      end
      case ({push, load})
        2'b10: cnt_q <= (AW+1)'(cnt_q + 1'b1);
        2'b01: cnt_q <= (AW+1)'(cnt_q - 1'b1);
        default: cnt_q <= cnt_q;
      endcase
    end
  end

  // Output register refills from storage as soon as it is taken
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      out_valid <= 1'b0;
      out_data <= '0;
    end
    else if (load)
    begin
      out_valid <= 1'b1;
      out_data <= mem[rd_ptr_q];
    end
    else if (out_ready)
    begin
      out_valid <= 1'b0;
    end
  end

endmodule // cpsc_fifo

// [cpsc_cmd.sv]
// Serial port settings and carrier information command handler
// Notes on behaviour
// RL1: Function 0x45 with sub-function 0x00 reads serial settings.
// RL2: Read answer header: sub-function, port count, current port number.
// RL3: One 13-byte record per port follows, port number first.
// RL4: Baud rate at byte 1, four bytes, one of five fixed rates.
// RL5: Data size at byte 5 is always 8.
// RL6: Parity at byte 6: 0 none, 1 odd, 2 even.
// RL7: Stop bits at byte 7 are 1 or 2; flow control at byte 8 is 0.
// RL8: Bus address at byte 9 lies from 1 to 247.
// RL9: Echo cap at byte 10 never exceeds 40.
// RL10: Resolution at byte 11: 1 m, 10 dm, 100 cm, 1000 mm.
// RL11: Sub-function 0x01 writes records, answered by echoing 0x01.
// RL12: Each written record goes to the port its first byte names.
// RL13: Sub-function 0x02 returns 32-byte firmware part and 8-byte version.
// RL14: Sub-function 0x03 returns hardware part, serial, four option bytes.
// RL15: An invalid written value answers with exception code 3.
// RL16: Multi-byte numbers travel least significant byte first.
`timescale 1ns/1ps
`include "cpsc_defs.svh"
module cpsc_cmd
  import cpsc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic req_valid,
  input wire logic [7:0] req_data,
  input wire logic req_last,
  output logic req_ready,
  input wire logic [7:0] cur_port,
  input wire logic [255:0] fw_part,
  input wire logic [63:0] fw_ver,
  input wire logic [255:0] hw_part,
  input wire logic [255:0] hw_serial,
  input wire logic [31:0] hw_opt,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_last,
  input wire logic rsp_ready,
  output logic [`CPSC_NPORT-1:0][31:0] cfg_baud,
  output logic [`CPSC_NPORT-1:0][7:0] cfg_parity,
  output logic [`CPSC_NPORT-1:0][7:0] cfg_stop,
  output logic [`CPSC_NPORT-1:0][7:0] cfg_addr,
  output logic [`CPSC_NPORT-1:0][7:0] cfg_max_echo,
  output logic [`CPSC_NPORT-1:0][15:0] cfg_res
);

  // --------------------------------------------------------------------------
  // Field checks
  // --------------------------------------------------------------------------
  function automatic logic baud_ok(input logic [31:0] b);
    return b == `CPSC_BAUD_9600 || b == `CPSC_BAUD_19200 || b == `CPSC_BAUD_38400 ||
           b == `CPSC_BAUD_57600 || b == `CPSC_BAUD_115200;
  endfunction

  function automatic logic res_ok(input logic [15:0] r);
    return r == `CPSC_RES_M || r == `CPSC_RES_DM || r == `CPSC_RES_CM || r == `CPSC_RES_MM;
  endfunction

  function automatic logic echo_ok(input logic [7:0] e);
    return e >= `CPSC_ECHO_MIN && e <= `CPSC_ECHO_MAX;
  endfunction

  function automatic logic addr_ok(input logic [7:0] a);
    return a >= `CPSC_ADDR_MIN && a <= `CPSC_ADDR_MAX;
  endfunction

  // Byte k of an ASCII string, first character in the top byte
  function automatic logic [7:0] str_byte(input logic [255:0] s, input logic [4:0] k);
    logic [255:0] t;
    t = s >> {~k, 3'b000};
    return t[7:0];
  endfunction

  // Byte k of a little-endian word
  function automatic logic [7:0] le_byte(input logic [63:0] w, input logic [2:0] k);
    logic [63:0] t;
    t = w >> {k, 3'b000};
    return t[7:0];
  endfunction

  // --------------------------------------------------------------------------
  // Request side
  // --------------------------------------------------------------------------
  cpsc_state_t state_q;
  logic req_ready_q;
  logic [7:0] sub_q;
  logic exc_q;
  logic [7:0] code_q;
  logic err_q;
  logic pend_q;
  logic [7:0] idx_q;
  logic [3:0] off_q;
  logic [7:0] rec_q;
  logic [7:0] buf_q [0:11];
  logic req_fire;
  logic rec_done;
  logic rec_good;
  logic [31:0] wr_baud;
  logic [15:0] wr_res;
  logic [`CPSC_PORT_W-1:0] rp;
  logic [7:0] ans_byte;
  logic ans_last;
  logic fifo_ready;
  logic push;
  logic [`CPSC_FIFO_W-1:0] fifo_out;

  assign req_ready = req_ready_q;
  assign req_fire = req_valid && req_ready_q;
  assign rec_done = req_fire && state_q == st_rec && off_q == `CPSC_REC_LAST;
  assign wr_baud = {buf_q[4], buf_q[3], buf_q[2], buf_q[1]}; // RL16
  assign wr_res = {req_data, buf_q[`CPSC_OFF_RES]}; // RL16
  assign rec_good = buf_q[`CPSC_OFF_PORT] < 8'(`CPSC_NPORT) && baud_ok(wr_baud) && // RL4
                    buf_q[`CPSC_OFF_SIZE] == `CPSC_SIZE_8 && // RL5
                    buf_q[`CPSC_OFF_PARITY] <= `CPSC_PAR_EVEN && // RL6
                    (buf_q[`CPSC_OFF_STOP] == `CPSC_STOP_1 || buf_q[`CPSC_OFF_STOP] == `CPSC_STOP_2) && // RL7
                    buf_q[`CPSC_OFF_FLOW] == `CPSC_FLOW_NONE && // RL7
                    addr_ok(buf_q[`CPSC_OFF_ADDR]) && // RL8
                    echo_ok(buf_q[`CPSC_OFF_ECHO]) && res_ok(wr_res); // RL9 RL10
  assign push = state_q == st_ans && fifo_ready;
  assign rp = rec_q[`CPSC_PORT_W-1:0];

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q <= st_func;
      req_ready_q <= 1'b1;
      sub_q <= 8'h00;
      exc_q <= 1'b0;
      code_q <= 8'h00;
      err_q <= 1'b0;
      pend_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        st_func:
          if (req_fire)
          begin
            err_q <= 1'b0;
            exc_q <= 1'b0;
            if (req_data == `CPSC_FUNC_PORT)
            begin
              if (req_last)
              begin
                exc_q <= 1'b1;
                code_q <= `CPSC_EXC_ILL_VAL;
                state_q <= st_ans;
                req_ready_q <= 1'b0;
              end
              else
              begin
                state_q <= st_sub;
              end
            end
            else if (!req_last)
            begin
              pend_q <= 1'b0;
              state_q <= st_skip;
            end
          end
        st_sub:
          if (req_fire)
          begin
            sub_q <= req_data;
            if (req_data == `CPSC_SUB_WR && !req_last)
            begin
              state_q <= st_rec; // RL11
            end
            else
            begin
              if (req_data > `CPSC_SUB_HW)
              begin
                exc_q <= 1'b1;
                code_q <= `CPSC_EXC_ILL_FUNC;
              end
              if (req_last)
              begin
                state_q <= st_ans; // RL1
                req_ready_q <= 1'b0;
              end
              else
              begin
                pend_q <= 1'b1;
                state_q <= st_skip;
              end
            end
          end
        st_rec:
          if (req_fire)
          begin
            if (rec_done && !rec_good)
            begin
              err_q <= 1'b1; // RL15
            end
            if (req_last)
            begin
              exc_q <= err_q || !rec_done || !rec_good; // RL15
              code_q <= `CPSC_EXC_ILL_VAL;
              state_q <= st_ans;
              req_ready_q <= 1'b0;
            end
          end
        st_skip:
          if (req_fire && req_last)
          begin
            state_q <= pend_q ? st_ans : st_func;
            req_ready_q <= !pend_q;
          end
        st_ans:
          if (push && ans_last)
          begin
            state_q <= st_func;
            req_ready_q <= 1'b1;
          end
        default:
        begin
          state_q <= st_func;
          req_ready_q <= 1'b1;
        end
      endcase
    end
  end

  // Record bytes are held until the last one arrives and the record is checked
  always_ff @(posedge clk)
  begin
    if (state_q == st_rec && req_fire && off_q != `CPSC_REC_LAST)
    begin
      buf_q[off_q] <= req_data;
    end
  end

  // --------------------------------------------------------------------------
  // Byte counters for collection and answer
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      idx_q <= 8'd0;
      off_q <= 4'd0;
      rec_q <= 8'd0;
    end
    else if (state_q == st_rec)
    begin
      if (req_fire)
      begin
        off_q <= (req_last || off_q == `CPSC_REC_LAST) ? 4'd0 : 4'(off_q + 1'b1); // RL3
      end
    end
    else if (state_q == st_ans)
    begin
      if (push)
      begin
        idx_q <= 8'(idx_q + 1'b1);
        if (!exc_q && sub_q == `CPSC_SUB_RD && idx_q >= `CPSC_A_RD_REC)
        begin
          off_q <= (off_q == `CPSC_REC_LAST) ? 4'd0 : 4'(off_q + 1'b1); // RL3
          rec_q <= (off_q == `CPSC_REC_LAST) ? 8'(rec_q + 1'b1) : rec_q;
        end
      end
    end
    else
    begin
      idx_q <= 8'd0;
      off_q <= 4'd0;
      rec_q <= 8'd0;
    end
  end

  // --------------------------------------------------------------------------
  // Port settings
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < `CPSC_NPORT; i++)
      begin
        cfg_baud[i] <= `CPSC_RST_BAUD;
        cfg_parity[i] <= `CPSC_RST_PARITY;
        cfg_stop[i] <= `CPSC_RST_STOP;
        cfg_addr[i] <= `CPSC_RST_ADDR;
        cfg_max_echo[i] <= `CPSC_RST_ECHO;
        cfg_res[i] <= `CPSC_RST_RES;
      end
    end
    else if (rec_done && rec_good)
    begin
      for (int i = 0; i < `CPSC_NPORT; i++)
      begin
        if (buf_q[`CPSC_OFF_PORT] == 8'(i))
        begin
          cfg_baud[i] <= wr_baud; // RL12
          cfg_parity[i] <= buf_q[`CPSC_OFF_PARITY];
          cfg_stop[i] <= buf_q[`CPSC_OFF_STOP];
          cfg_addr[i] <= buf_q[`CPSC_OFF_ADDR];
          cfg_max_echo[i] <= buf_q[`CPSC_OFF_ECHO]; // RL9
          cfg_res[i] <= wr_res;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Answer byte selection
  // --------------------------------------------------------------------------
  always_comb
  begin
    ans_byte = 8'h00;
    ans_last = 1'b0;
    if (exc_q)
    begin
      ans_byte = (idx_q == 8'd0) ? `CPSC_FUNC_EXC : code_q; // RL15
      ans_last = idx_q == 8'd1;
    end
    else if (idx_q == 8'd0)
    begin
      ans_byte = `CPSC_FUNC_PORT;
    end
    else if (idx_q == 8'd1)
    begin
      ans_byte = sub_q; // RL11
      ans_last = sub_q == `CPSC_SUB_WR;
    end
    else
    begin
      case (sub_q)
        `CPSC_SUB_RD:
        begin
          ans_last = idx_q == `CPSC_A_RD_LAST; // RL3
          if (idx_q == `CPSC_A_RD_NPORT)
            ans_byte = 8'(`CPSC_NPORT); // RL2
          else if (idx_q == `CPSC_A_RD_CUR)
            ans_byte = cur_port; // RL2
          else
          begin
            case (off_q)
              `CPSC_OFF_PORT: ans_byte = rec_q; // RL3
              4'd1, 4'd2, 4'd3, 4'd4: ans_byte = le_byte({32'h0, cfg_baud[rp]}, 3'(off_q - 4'd1)); // RL16
              `CPSC_OFF_SIZE: ans_byte = `CPSC_SIZE_8; // RL5
              `CPSC_OFF_PARITY: ans_byte = cfg_parity[rp];
              `CPSC_OFF_STOP: ans_byte = cfg_stop[rp];
              `CPSC_OFF_FLOW: ans_byte = `CPSC_FLOW_NONE;
              `CPSC_OFF_ADDR: ans_byte = cfg_addr[rp];
              `CPSC_OFF_ECHO: ans_byte = cfg_max_echo[rp];
              `CPSC_OFF_RES: ans_byte = cfg_res[rp][7:0];
              default: ans_byte = cfg_res[rp][15:8];
            endcase
          end
        end
        `CPSC_SUB_FW:
        begin
          ans_last = idx_q == `CPSC_A_FW_LAST; // RL13
          if (idx_q < `CPSC_A_FW_VER)
            ans_byte = str_byte(fw_part, 5'(idx_q - `CPSC_A_PART));
          else
            ans_byte = le_byte(fw_ver, 3'(idx_q - `CPSC_A_FW_VER));
        end
        `CPSC_SUB_HW:
        begin
          ans_last = idx_q == `CPSC_A_HW_LAST; // RL14
          if (idx_q < `CPSC_A_HW_SER)
            ans_byte = str_byte(hw_part, 5'(idx_q - `CPSC_A_PART));
          else if (idx_q < `CPSC_A_HW_OPT)
            ans_byte = str_byte(hw_serial, 5'(idx_q - `CPSC_A_HW_SER));
          else
            ans_byte = le_byte({32'h0, hw_opt}, 3'(idx_q - `CPSC_A_HW_OPT));
        end
        default: ans_last = 1'b1;
      endcase
    end
  end

  cpsc_fifo #(
    .WIDTH(`CPSC_FIFO_W),
    .DEPTH(`CPSC_FIFO_D)
  ) u_fifo (
    .clk(clk),
    .rst_b(rst_b),
    .in_valid(state_q == st_ans),
    .in_data({ans_last, ans_byte}),
    .in_ready(fifo_ready),
    .out_valid(rsp_valid),
    .out_data(fifo_out),
    .out_ready(rsp_ready)
  );

  assign rsp_data = fifo_out[7:0];
  assign rsp_last = fifo_out[8];

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_rd_req;
    state_q == st_sub && req_fire && req_data == `CPSC_SUB_RD && req_last;
  endsequence
  sequence s_bad_rec;
    rec_done && !rec_good;
  endsequence

  a_rd_decode: assert property (s_rd_req |=> state_q == st_ans && !exc_q && sub_q == `CPSC_SUB_RD) // RL1
    else $error("read request not decoded");
  a_rd_header: assert property (push && !exc_q && sub_q == `CPSC_SUB_RD // RL2
    && (idx_q == `CPSC_A_RD_NPORT || idx_q == `CPSC_A_RD_CUR)
    |-> ans_byte == (idx_q == `CPSC_A_RD_NPORT ? 8'(`CPSC_NPORT) : cur_port))
    else $error("read header wrong");
  a_rd_length: assert property (push && ans_last && !exc_q && sub_q == `CPSC_SUB_RD |-> idx_q == 8'd29) // RL3
    else $error("read answer length wrong");
  a_baud_lsb: assert property (push && !exc_q && sub_q == `CPSC_SUB_RD && idx_q >= `CPSC_A_RD_REC // RL16
    && off_q == 4'd4 |-> ans_byte == cfg_baud[rp][31:24])
    else $error("baud byte order wrong");
  a_wr_ack: assert property (push && !exc_q && sub_q == `CPSC_SUB_WR && idx_q == 8'd1 // RL11
    |-> ans_byte == 8'h01 && ans_last)
    else $error("write ack wrong");
  a_wr_apply: assert property (rec_done && rec_good && buf_q[0] == 8'h01 // RL12
    |=> cfg_addr[1] == $past(buf_q[9]) && cfg_res[1] == $past(wr_res))
    else $error("record not applied to named port");
  a_fw_length: assert property (push && ans_last && !exc_q && sub_q == `CPSC_SUB_FW |-> idx_q == 8'd41) // RL13
    else $error("firmware answer length wrong");
  a_hw_length: assert property (push && ans_last && !exc_q && sub_q == `CPSC_SUB_HW |-> idx_q == 8'd69) // RL14
    else $error("hardware answer length wrong");
  a_bad_value: assert property (s_bad_rec |=> err_q || (exc_q && code_q == 8'h03)) // RL15
    else $error("invalid record not flagged");

  for (genvar g = 0; g < `CPSC_NPORT; g++)
  begin : g_chk
    a_baud_legal: assert property (baud_ok(cfg_baud[g])) // RL4
      else $error("illegal baud held");
    a_parity_stop: assert property (cfg_parity[g] <= 8'h02 && (cfg_stop[g] == 8'h01 || cfg_stop[g] == 8'h02)) // RL6 RL7
      else $error("illegal parity or stop held");
    a_addr_range: assert property (addr_ok(cfg_addr[g])) // RL8
      else $error("illegal address held");
    a_echo_cap: assert property (cfg_max_echo[g] <= 8'd40 && cfg_max_echo[g] != 8'd0) // RL9
      else $error("echo cap above 40");
    a_res_legal: assert property (res_ok(cfg_res[g])) // RL10
      else $error("illegal resolution held");
  end

endmodule // cpsc_cmd

// [cpsc_host.sv]
// Host master model: sends request messages and collects answer bytes
`timescale 1ns/1ps
module cpsc_host (
  input wire logic clk,
  output logic req_valid,
  output logic [7:0] req_data,
  output logic req_last,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_data,
  input wire logic rsp_last,
  output logic rsp_ready
);
  logic [8:0] rx_q[$];
  logic stall = 1'b0;
  logic [1:0] cnt = 2'h0;
  logic ok;

  initial
  begin
    req_valid = 1'b0;
    req_data = 8'h00;
    req_last = 1'b0;
    rsp_ready = 1'b1;
  end

  // When stalling, takes one answer byte in four cycles
  always @(posedge clk)
  begin
    cnt <= #1 cnt + 2'h1;
    rsp_ready <= #1 !stall || cnt == 2'h3;
  end

  always @(negedge clk)
    if (rsp_valid === 1'b1 && rsp_ready)
      rx_q.push_back({rsp_last, rsp_data});

  // Each byte is held until an edge that sees req_ready high
  task automatic send(input logic [7:0] m[$]);
    foreach (m[i])
    begin
      req_valid = 1'b1;
      req_data = m[i];
      req_last = (i == m.size() - 1);
      do
      begin
        @(negedge clk);
        ok = req_ready;
        @(posedge clk);
        #1;
      end while (ok !== 1'b1);
    end
    req_valid = 1'b0;
    req_data = ~req_data;
    req_last = 1'b0;
  endtask
endmodule // cpsc_host

// [carrier_port_settings_cmds_tb.sv]
// Self-checking bench for the port settings command handler
`timescale 1ns/1ps
`include "cpsc_defs.svh"
module carrier_port_settings_cmds_tb;
  logic clk, rst_b, req_valid, req_last, req_ready, rsp_valid, rsp_last, rsp_ready;
  logic [7:0] req_data, rsp_data, cur_port;
  logic [255:0] fw_part, hw_part, hw_serial;
  logic [63:0] fw_ver = 64'h0011223344556677;
  logic [31:0] hw_opt = 32'ha1b2c3d4;
  logic [1:0][31:0] cfg_baud;
  logic [1:0][7:0] cfg_parity, cfg_stop, cfg_addr, cfg_max_echo;
  logic [1:0][15:0] cfg_res;
  logic [31:0] e_baud [2] = '{32'd115200, 32'd115200};
  logic [7:0] e_par [2] = '{8'h00, 8'h00};
  logic [7:0] e_stop [2] = '{8'h01, 8'h01};
  logic [7:0] e_addr [2] = '{8'h01, 8'h01};
  logic [7:0] e_echo [2] = '{8'h28, 8'h28};
  logic [15:0] e_res [2] = '{16'd1000, 16'd1000};
  logic [31:0] bauds [5] = '{32'd9600, 32'd19200, 32'd38400, 32'd57600, 32'd115200};
  logic [15:0] ress [4] = '{16'd1, 16'd10, 16'd100, 16'd1000};
  logic [15:0] bad [12] = '{16'h0002, 16'h0181, 16'h0507, 16'h0603, 16'h0700, 16'h0703,
                            16'h0801, 16'h0900, 16'h09f8, 16'h0a00, 16'h0a29, 16'h0b05};
  logic [7:0] q[$], x[$];
  int bad_count = 0;
  int checked = 0;

  cpsc_cmd dut_u (.clk, .rst_b, .req_valid, .req_data, .req_last, .req_ready, .cur_port,
    .fw_part, .fw_ver, .hw_part, .hw_serial, .hw_opt, .rsp_valid, .rsp_data, .rsp_last,
    .rsp_ready, .cfg_baud, .cfg_parity, .cfg_stop, .cfg_addr, .cfg_max_echo, .cfg_res);
  cpsc_host host_u (.clk, .req_valid, .req_data, .req_last, .req_ready, .rsp_valid,
    .rsp_data, .rsp_last, .rsp_ready);

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic end_of_test();
    if (bad_count == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic fail(input logic [79:0] g, input logic [79:0] e);
    bad_count++;
    $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
  endtask

  task automatic cmp_cfg(input int p);
    checked++;
    if ({cfg_baud[p], cfg_parity[p], cfg_stop[p], cfg_addr[p], cfg_max_echo[p], cfg_res[p]} !==
        {e_baud[p], e_par[p], e_stop[p], e_addr[p], e_echo[p], e_res[p]})
      fail({cfg_baud[p], cfg_parity[p], cfg_stop[p], cfg_addr[p], cfg_max_echo[p], cfg_res[p]},
           {e_baud[p], e_par[p], e_stop[p], e_addr[p], e_echo[p], e_res[p]});
  endtask

  // Sends one message, waits for the answer and compares it byte by byte
  task automatic run(input logic [7:0] rq[$], input logic [7:0] ex[$]);
    int n;
    n = 0;
    host_u.send(rq);
    while (host_u.rx_q.size() < ex.size() && n < 2000)
    begin
      @(posedge clk);
      n++;
    end
    repeat (4) @(posedge clk);
    #1;
    checked++;
    if (host_u.rx_q.size() != ex.size())
      fail(host_u.rx_q.size(), ex.size());
    else
      foreach (ex[i])
        if (host_u.rx_q[i] !== {i == ex.size() - 1, ex[i]})
          fail(host_u.rx_q[i], {i == ex.size() - 1, ex[i]});
    host_u.rx_q.delete();
  endtask

  task automatic add_rec(ref logic [7:0] d[$], input logic [7:0] p, input logic [31:0] bd,
                         input logic [7:0] pa, sb, ad, ec, input logic [15:0] rs);
    d = {d, p, bd[7:0], bd[15:8], bd[23:16], bd[31:24], 8'h08, pa, sb, 8'h00, ad, ec,
         rs[7:0], rs[15:8]};
  endtask

  task automatic set_rec(input int p, input int k);
    e_baud[p] = bauds[k];
    e_par[p] = 8'(k % 3);
    e_stop[p] = 8'(1 + k % 2);
    e_addr[p] = k == 0 ? 8'h01 : k == 4 ? 8'hf7 : 8'(k * 60);
    e_echo[p] = k == 0 ? 8'h01 : 8'(k * 10);
    e_res[p] = ress[k % 4];
    add_rec(q, 8'(p), e_baud[p], e_par[p], e_stop[p], e_addr[p], e_echo[p], e_res[p]);
  endtask

  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  task automatic t_read(input logic [7:0] cp);
    cur_port = cp;
    x = {8'h45, 8'h00, 8'h02, cp};
    for (int p = 0; p < 2; p++)
      add_rec(x, 8'(p), e_baud[p], e_par[p], e_stop[p], e_addr[p], e_echo[p], e_res[p]);
    q = {8'h45, 8'h00};
    run(q, x);
  endtask

  // Two records per message, every encoding and both address and echo bounds
  task automatic t_write();
    for (int i = 0; i < 5; i++)
    begin
      q = {8'h45, 8'h01};
      set_rec(0, i);
      set_rec(1, 4 - i);
      run(q, {8'h45, 8'h01});
      cmp_cfg(0);
      cmp_cfg(1);
    end
  endtask

  task automatic t_bad();
    for (int k = 0; k < 12; k++)
    begin
      q = {8'h45, 8'h01};
      add_rec(q, 8'h00, 32'd9600, 8'h00, 8'h01, 8'h01, 8'h01, 16'd1);
      q[2 + bad[k][15:8]] = bad[k][7:0];
      run(q, {8'hc5, 8'h03});
      cmp_cfg(0);
      cmp_cfg(1);
    end
    q = {8'h45, 8'h01, 8'h00, 8'h80};
    run(q, {8'hc5, 8'h03});
    q = {8'h45};
    run(q, {8'hc5, 8'h03});
    q = {8'h45, 8'h01};
    run(q, {8'h45, 8'h01});
    q = {8'h45, 8'h04};
    run(q, {8'hc5, 8'h01});
    q = {8'h41, 8'h00};
    x.delete();
    run(q, x);
  endtask

  // Stalled sink fills the answer buffer
  task automatic t_info();
    host_u.stall = 1'b1;
    x = {8'h45, 8'h02};
    for (int i = 31; i >= 0; i--) x.push_back(fw_part[8*i +: 8]);
    for (int i = 0; i < 8; i++) x.push_back(fw_ver[8*i +: 8]);
    q = {8'h45, 8'h02, 8'haa};
    run(q, x);
    x = {8'h45, 8'h03};
    for (int i = 31; i >= 0; i--) x.push_back(hw_part[8*i +: 8]);
    for (int i = 31; i >= 0; i--) x.push_back(hw_serial[8*i +: 8]);
    for (int i = 0; i < 4; i++) x.push_back(hw_opt[8*i +: 8]);
    q = {8'h45, 8'h03};
    run(q, x);
    t_read(8'h00);
    host_u.stall = 1'b0;
  endtask

  initial
  begin
    rst_b = 1'b0;
    cur_port = 8'h01;
    for (int i = 0; i < 32; i++)
    begin
      fw_part[8*i +: 8] = 8'(i);
      hw_part[8*i +: 8] = 8'(64 + i);
      hw_serial[8*i +: 8] = 8'(128 + i);
    end
    repeat (12) @(posedge clk);
    #1;
    rst_b = 1'b1;
    cmp_cfg(0);
    cmp_cfg(1);
    t_read(8'h01);
    t_write();
    t_read(8'h01);
    t_bad();
    t_info();
    end_of_test();
  end

  initial
  begin
    #160000;
    bad_count++;
    end_of_test();
  end
endmodule // carrier_port_settings_cmds_tb
